/* src/ipc_consts.vh */
// Constants for the input-only port C block and its pin-state logic.
// Assumes inclusion by the port module and the bench; definitions only, no logic.
`ifndef IPC_CONSTS_VH
`define IPC_CONSTS_VH

// ---------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------
// Printed offset is not word aligned, so it is kept as an index
`define IPC_LEVEL_C_INDEX   18'h0ffde
// Byte address of the data register is four times its index
`define IPC_LEVEL_C_ADDR    18'h3ff78
`define IPC_ADDR_W          18

// ---------------------------------------------------------------------
// Field layout of the data register
// ---------------------------------------------------------------------
`define IPC_PIN_LSB         0
`define IPC_PIN_MSB         3
`define IPC_PIN_W           4
`define IPC_PAD_LSB         4
`define IPC_PAD_MSB         7
`define IPC_PAD_VALUE       4'hf
`define IPC_PORT_B_W        8

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define IPC_LEVEL_RESET     4'h0
`define IPC_SYNC_RESET      4'h0

// ---------------------------------------------------------------------
// Operating mode codes on the op_mode input
// ---------------------------------------------------------------------
`define IPC_MODE_W          3
`define IPC_MODE_RESET      3'h0
`define IPC_MODE_SLEEP      3'h1
`define IPC_MODE_SUBSLEEP   3'h2
`define IPC_MODE_STANDBY    3'h3
`define IPC_MODE_WATCH      3'h4
`define IPC_MODE_SUBACTIVE  3'h5
`define IPC_MODE_ACTIVE     3'h6

// ---------------------------------------------------------------------
// AXI4-Lite response codes
// ---------------------------------------------------------------------
`define IPC_RESP_OKAY       2'h0
`define IPC_RESP_DECERR     2'h3

`endif

/* src/ipc_port_c.v */
// Input-only port C with its read-only level register on AXI4-Lite,
// plus the pin-state drive of the analog-input port B.
// Assumes one 50 MHz clock, synchronous active-low reset, and a power
// controller that presents the chip operating mode on op_mode.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "ipc_consts.vh"

module ipc_port_c
(
   input  wire                         aclk,
   input  wire                         aresetn,
   // AXI4-Lite write address
   input  wire [`IPC_ADDR_W-1:0]       s_axi_awaddr,
   input  wire [2:0]                   s_axi_awprot,
   input  wire                         s_axi_awvalid,
   output wire                         s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0]                  s_axi_wdata,
   input  wire [3:0]                   s_axi_wstrb,
   input  wire                         s_axi_wvalid,
   output wire                         s_axi_wready,
   // AXI4-Lite write response
   output wire [1:0]                   s_axi_bresp,
   output wire                         s_axi_bvalid,
   input  wire                         s_axi_bready,
   // AXI4-Lite read address
   input  wire [`IPC_ADDR_W-1:0]       s_axi_araddr,
   input  wire [2:0]                   s_axi_arprot,
   input  wire                         s_axi_arvalid,
   output wire                         s_axi_arready,
   // AXI4-Lite read data
   output wire [31:0]                  s_axi_rdata,
   output wire [1:0]                   s_axi_rresp,
   output wire                         s_axi_rvalid,
   input  wire                         s_axi_rready,
   // Chip operating mode
   input  wire [`IPC_MODE_W-1:0]       op_mode,
   // Converter output selection from the converter control register
   input  wire                         converter_master_enable,
   input  wire [`IPC_PIN_W-1:0]        converter_pin_output_enables,
   // Port C pins, three signals each
   input  wire [`IPC_PIN_W-1:0]        port_c_pin_bits_in,
   output wire [`IPC_PIN_W-1:0]        port_c_pin_bits_out,
   output wire [`IPC_PIN_W-1:0]        port_c_pin_bits_oe_n,
   // Port B pins shared with the analog input channels
   input  wire [`IPC_PORT_B_W-1:0]     port_b_pin_bits_in,
   output wire [`IPC_PORT_B_W-1:0]     port_b_pin_bits_out,
   output wire [`IPC_PORT_B_W-1:0]     port_b_pin_bits_oe_n
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   reg  [`IPC_PIN_W-1:0]   sync1_q;
   reg  [`IPC_PIN_W-1:0]   sync2_q;
   reg  [`IPC_PIN_W-1:0]   level_q;
   reg  [`IPC_PIN_W-1:0]   level_d;
   reg                     aw_got_q;
   reg                     w_got_q;
   reg  [`IPC_ADDR_W-1:0]  awaddr_q;
   reg                     bvalid_q;
   reg  [1:0]              bresp_q;
   reg                     rvalid_q;
   reg  [1:0]              rresp_q;
   reg  [31:0]             rdata_q;
   wire                    aw_fire;
   wire                    w_fire;
   wire                    ar_fire;
   wire [`IPC_ADDR_W-1:0]  wr_addr;
   wire [`IPC_PIN_W-1:0]   pin_view;

   // Byte address at bus width, so its word part can be sliced
   localparam [`IPC_ADDR_W-1:0] LVL_ADDR = `IPC_LEVEL_C_ADDR;

   // Word-aligned decode of the single mapped register
   function hit_level_reg;
      input [`IPC_ADDR_W-1:0] addr;
      begin
         hit_level_reg = (addr[`IPC_ADDR_W-1:2] ==
                          LVL_ADDR[`IPC_ADDR_W-1:2]);
      end
   endfunction

   // ------------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------------
   // Port B never driven
   assign port_b_pin_bits_out  = {`IPC_PORT_B_W{1'b0}};
   assign port_b_pin_bits_oe_n = {`IPC_PORT_B_W{1'b1}};
   // High-Z in every mode
   // The analog output drive belongs to the converter, not this port.
   assign port_c_pin_bits_out  = {`IPC_PIN_W{1'b0}};
   assign port_c_pin_bits_oe_n = {`IPC_PIN_W{1'b1}};

   // ------------------------------------------------------------------
   // Pin sampling
   // ------------------------------------------------------------------
   // Two-stage synchroniser; pins are asynchronous to aclk
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_q <= `IPC_SYNC_RESET;
         sync2_q <= `IPC_SYNC_RESET;
      end
      else
      begin
         sync1_q <= port_c_pin_bits_in;
         sync2_q <= sync1_q;
      end
   end

   // Mode-dependent level state
   // Sleep, subsleep and watch freeze the last seen level; standby, reset
   // and unused code 7 drop it, since the input buffers are off there.
   always @*
   begin
      case (op_mode)
         `IPC_MODE_ACTIVE,
         `IPC_MODE_SUBACTIVE : level_d = sync2_q;
         `IPC_MODE_SLEEP,
         `IPC_MODE_SUBSLEEP,
         `IPC_MODE_WATCH     : level_d = level_q;
         default             : level_d = `IPC_LEVEL_RESET;
      endcase
   end

   always @(posedge aclk)
   begin
      if (!aresetn)
         level_q <= `IPC_LEVEL_RESET;
      else
         level_q <= level_d;
   end

   // Converter outputs read 0
   // Masking uses the enables only, so the analog voltage never leaks.
   genvar gi;
   generate
      for (gi = 0; gi < `IPC_PIN_W; gi = gi + 1)
      begin : g_mask
         assign pin_view[gi] = level_q[gi] &
            ~(converter_master_enable & converter_pin_output_enables[gi]);
      end
   endgenerate

   // ------------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------------
   // Address and data taken in either order; response after both
   assign s_axi_awready = !aw_got_q && !bvalid_q;
   assign s_axi_wready  = !w_got_q && !bvalid_q;
   assign aw_fire       = s_axi_awvalid && s_axi_awready;
   assign w_fire        = s_axi_wvalid && s_axi_wready;
   assign wr_addr       = aw_fire ? s_axi_awaddr : awaddr_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         awaddr_q <= {`IPC_ADDR_W{1'b0}};
         bvalid_q <= 1'b0;
         bresp_q  <= `IPC_RESP_OKAY;
      end
      else if (bvalid_q)
      begin
         if (s_axi_bready)
            bvalid_q <= 1'b0;
      end
      else if ((aw_got_q || aw_fire) && (w_got_q || w_fire))
      begin
         aw_got_q <= 1'b0;
         w_got_q  <= 1'b0;
         bvalid_q <= 1'b1;
         if (hit_level_reg(wr_addr))
            bresp_q <= `IPC_RESP_OKAY;
         else
            bresp_q <= `IPC_RESP_DECERR;
      end
      else
      begin
         if (aw_fire)
         begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (w_fire)
            w_got_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------------
   assign s_axi_arready = !rvalid_q;
   assign ar_fire       = s_axi_arvalid && s_axi_arready;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rresp_q  <= `IPC_RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end
      else if (ar_fire)
      begin
         rvalid_q <= 1'b1;
         if (hit_level_reg(s_axi_araddr))
         begin
            rresp_q <= `IPC_RESP_OKAY;
            rdata_q <= {24'h00_0000, `IPC_PAD_VALUE, pin_view};
         end
         else
         begin
            rresp_q <= `IPC_RESP_DECERR;
            rdata_q <= 32'h0000_0000;
         end
      end
      else if (rvalid_q && s_axi_rready)
         rvalid_q <= 1'b0;
   end

endmodule // ipc_port_c

/* sim/ipc_port_c_properties.sv */
// Checker for the port C block: bus timing and pin drive.
// Assumes bind onto ipc_port_c and sees its ports only.
`timescale 1ns/100ps
// ---------------------------------------------------------
// Checker
// ---------------------------------------------------------
module ipc_port_c_chk
(
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        converter_master_enable,
   input wire [3:0]  converter_pin_output_enables,
   input wire [3:0]  port_c_pin_bits_oe_n,
   input wire [7:0]  port_b_pin_bits_oe_n
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
   sequence s_wd; s_axi_wvalid && s_axi_wready; endsequence
   sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
   property p_wresp; s_aw and s_wd |=> s_axi_bvalid; endproperty
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   property p_rlat; s_ar |=> s_axi_rvalid; endproperty
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_pad;
      s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[31:4] == 28'hf;
   endproperty
   property p_mask; s_ar ##0 converter_master_enable |=>
      (s_axi_rdata[3:0] & $past(converter_pin_output_enables)) == 4'h0;
   endproperty
   property p_bhiz; port_b_pin_bits_oe_n == 8'hff; endproperty
   property p_chiz; port_c_pin_bits_oe_n == 4'hf; endproperty
   a_wresp: assert property (p_wresp) else $error("no write answer");
   a_bhold: assert property (p_bhold) else $error("bresp moved");
   a_bdone: assert property (p_bdone) else $error("bvalid stuck");
   a_rlat: assert property (p_rlat) else $error("read late");
   a_rhold: assert property (p_rhold) else $error("rdata moved");
   a_pad: assert property (p_pad) else $error("upper bits wrong");
   a_mask: assert property (p_mask) else $error("mask missed");
   a_bhiz: assert property (p_bhiz) else $error("port b driven");
   a_chiz: assert property (p_chiz) else $error("port c driven");
endmodule // ipc_port_c_chk
bind ipc_port_c ipc_port_c_chk ipc_port_c_chk_i (.*);

/* sim/ipc_port_c_tb.sv */
// Self-checking bench for the port C block over AXI4-Lite.
// Assumes the checker is bound separately; 50 MHz clock.
`timescale 1ns/100ps
`include "ipc_consts.vh"
// ---------------------------------------------------------
// Bench top
// ---------------------------------------------------------
module ipc_port_c_tb_top;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic converter_master_enable;
   logic [17:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, s;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  s_axi_awprot, s_axi_arprot, op_mode;
   logic [3:0]  s_axi_wstrb, converter_pin_output_enables, p;
   logic [3:0]  port_c_pin_bits_in, port_c_pin_bits_out;
   logic [3:0]  port_c_pin_bits_oe_n;
   logic [7:0]  port_b_pin_bits_in, port_b_pin_bits_out;
   logic [7:0]  port_b_pin_bits_oe_n;
   logic [33:0] rq[$], bq[$];
   // Late ready on alternate passes, so held answers are exercised
   logic stall;
   wire [33:0] pb_seen = {18'h0, port_b_pin_bits_oe_n, port_b_pin_bits_out};
   wire [33:0] pc_seen = {26'h0, port_c_pin_bits_oe_n, port_c_pin_bits_out};
   int errors, check_count, m;
   localparam A = `IPC_LEVEL_C_ADDR;
   ipc_port_c ipc_port_c_i (.*);
   initial begin aclk = 0; forever #10 aclk = ~aclk; end
   function [31:0] lfsr(input [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task chk(input [33:0] seen, input [33:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("FAIL %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Read: hold request until taken, rready until rvalid
   task rd(input [17:0] a, input [33:0] e);
      rq.push_back(e);
      s_axi_arvalid <= 1; s_axi_araddr <= a; s_axi_rready <= !stall;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      if (stall)
      begin
         repeat (2) @(posedge aclk);
         s_axi_rready <= 1;
      end
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 0;
      @(posedge aclk);
   endtask
   // Write: address and data offered together, each freed when taken
   task wr(input [17:0] a, input [1:0] e);
      reg ta, tw;
      ta = 0; tw = 0; bq.push_back({32'h0, e}); s = lfsr(s);
      s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= !stall;
      s_axi_awaddr <= a; s_axi_wdata <= s;
      while (!(ta && tw))
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin ta = 1; s_axi_awvalid <= 0; end
         if (s_axi_wvalid && s_axi_wready) begin tw = 1; s_axi_wvalid <= 0; end
      end
      if (stall)
      begin
         repeat (2) @(posedge aclk);
         s_axi_bready <= 1;
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 0;
      @(posedge aclk);
   endtask
   // Monitor takes the oldest note when a result shows
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, bq.pop_front());
      // Pin drive stays off in every cycle and mode
      chk(pb_seen, {18'h0, 8'hff, 8'h00});
      chk(pc_seen, {26'h0, 4'hf, 4'h0});
   end
   // Watchdog, well past the few hundred cycles needed
   initial begin repeat (5000) @(posedge aclk); errors++; end_sim; end
   initial
   begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
      {s_axi_rready, converter_master_enable, s_axi_awaddr} = 0;
      {s_axi_araddr, s_axi_wdata, converter_pin_output_enables} = 0;
      s_axi_awprot = 0; s_axi_arprot = 0; s_axi_wstrb = 4'hf;
      port_b_pin_bits_in = 8'h5a; port_c_pin_bits_in = 0;
      op_mode = `IPC_MODE_ACTIVE; aresetn = 0; s = 32'ha6f9;
      stall = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      // Random pins and converter selections, mask per pin
      repeat (8)
      begin
         s = lfsr(s); p = s[3:0] & ~({4{s[4]}} & s[8:5]);
         stall = ~stall;
         port_c_pin_bits_in <= s[3:0]; converter_master_enable <= s[4];
         converter_pin_output_enables <= s[8:5];
         repeat (4) @(posedge aclk);
         rd(A, {30'hf, p});
         wr(A, `IPC_RESP_OKAY); rd(A, {30'hf, p});
      end
      converter_master_enable <= 0;
      // Unmapped place refused both ways
      wr(18'h00010, `IPC_RESP_DECERR); rd(18'h00010, {2'h3, 32'h0});
      // Each operating mode, unused code 7 too: pins change on entry
      for (m = 0; m < 8; m++)
      begin
         s = lfsr(s); op_mode <= `IPC_MODE_ACTIVE; port_c_pin_bits_in <= s[3:0];
         repeat (4) @(posedge aclk);
         op_mode <= m[2:0]; port_c_pin_bits_in <= ~s[3:0];
         repeat (4) @(posedge aclk);
         p = (m == 5 || m == 6) ? ~s[3:0] :
             (m == 1 || m == 2 || m == 4) ? s[3:0] : 4'h0;
         // hi-Z reads 0, hold keeps old, live follows
         rd(A, {30'hf, p});
      end
      end_sim;
   end
endmodule // ipc_port_c_tb_top
